//--- twowire_pkg.sv
// twowire_pkg: register map, field positions, status codes, carriers and
// engine states for the software-handshaked two-wire master transmitter.
// assumes: 32-bit APB, registers in the low bits of aligned words.
`default_nettype none

package twowire_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam int          ADDR_W      = 8;
   localparam logic [7:0]  OFF_CONTROL = 8'h00;
   localparam logic [7:0]  OFF_STATUS  = 8'h04;
   localparam logic [7:0]  OFF_SHIFT   = 8'h08;

   // control register bit positions
   localparam int CTL_DONE   = 7;
   localparam int CTL_ACK_EN = 6;
   localparam int CTL_START  = 5;
   localparam int CTL_STOP   = 4;
   localparam int CTL_WCOL   = 3;
   localparam int CTL_ENABLE = 2;
   localparam int CTL_IRQ_EN = 0;

   // status register layout
   localparam int ST_CODE_LSB = 3;
   localparam int ST_CODE_W   = 5;
   localparam int ST_PRESC_W  = 2;

   // ************************************************************
   // reset values and status codes
   // ************************************************************
   localparam logic [7:0]           SHIFT_RESET    = 8'hFF;
   localparam logic [ST_CODE_W-1:0] CODE_IDLE      = 5'h1F;
   localparam logic [ST_CODE_W-1:0] CODE_START     = 5'h01;
   localparam logic [ST_CODE_W-1:0] CODE_ADDR_ACK  = 5'h03;
   localparam logic [ST_CODE_W-1:0] CODE_ADDR_NACK = 5'h04;
   localparam logic [ST_CODE_W-1:0] CODE_DATA_ACK  = 5'h05;
   localparam logic [ST_CODE_W-1:0] CODE_DATA_NACK = 5'h06;

   // ************************************************************
   // link timing
   // ************************************************************
   localparam int CNT_W        = 12;
   localparam int QUARTER_DEF  = 100;
   localparam int BITS_LAST    = 7;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef enum logic [1:0]
   {
      OP_START = 2'h0,
      OP_BYTE  = 2'h1,
      OP_STOP  = 2'h2
   } op_kind_t;

   typedef enum logic [1:0]
   {
      EV_START = 2'h0,
      EV_ADDR  = 2'h1,
      EV_DATA  = 2'h2,
      EV_STOP  = 2'h3
   } ev_kind_t;

   typedef struct packed
   {
      op_kind_t   kind;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed
   {
      ev_kind_t kind;
      logic     nack;
   } done_t;

   typedef enum logic [6:0]
   {
      S_IDLE      = 7'b0000001,
      S_WAIT_FREE = 7'b0000010,
      S_START     = 7'b0000100,
      S_BIT       = 7'b0001000,
      S_ACK       = 7'b0010000,
      S_STOP      = 7'b0100000,
      S_HOLD      = 7'b1000000
   } eng_state_t;

endpackage : twowire_pkg

`default_nettype wire

//--- bit_sync.sv
// bit_sync: two flip-flop synchroniser for levels and toggles.
// assumes: each bit is a level or toggle that holds for several
// destination clocks; words are held stable by their sender.
`default_nettype none

module bit_sync
#(
   parameter int WIDTH = 1
)
(
   // destination clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // meta is read by q alone
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : bit_sync

`default_nettype wire

//--- twowire_sw_handshake_master_tx.sv
// twowire_sw_handshake_master_tx: APB register front end and two-wire
// master transmit engine, handshaked by an operation-done flag.
// assumes: open-drain pads resolved outside; link_clk runs free.
//
// How it works
// - every finished bus event except STOP sets the operation-done flag
// - irq rises only with flag, op irq enable and cpu irq enable set
// - a status code is posted whenever the done flag is set
// - writing one to the done bit of control clears the flag
// - no new bus operation starts while the done flag is set
// - clearing the flag launches START, address/data byte or STOP
// - after a sent START, flag sets with the START status code
// - after a sent byte, status shows whether the slave acknowledged
// - one shift register carries address-with-write and data bytes
// - finishing a STOP does not set the done flag
// - SCL is held low while the done flag is set
// - START waits for a STOP when another master holds the bus
// - STOP request bit clears itself once the STOP is executed
// - shift write with flag low sets write collision, with flag high clears
// - status holds the code in its top five bits beside the prescaler
`default_nettype none

module twowire_sw_handshake_master_tx
#(
   parameter int QUARTER_CYCLES = twowire_pkg::QUARTER_DEF
)
(
   // system clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // apb slave
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [twowire_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                    pwdata,
   output logic      [31:0]                    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // interrupt request
   input  wire logic                           cpu_irq_enable,
   output logic                                irq,
   // link clock and bus pins
   input  wire logic                           link_clk,
   input  wire logic                           scl_i,
   output logic                                scl_o,
   output logic                                scl_oe,
   input  wire logic                           sda_i,
   output logic                                sda_o,
   output logic                                sda_oe
);

   if (QUARTER_CYCLES < 2 || QUARTER_CYCLES >= (1 << twowire_pkg::CNT_W))
   begin : g_bad_quarter
      $error("QUARTER_CYCLES out of range");
   end

   localparam logic [twowire_pkg::CNT_W-1:0] CNT_LAST =
      twowire_pkg::CNT_W'(QUARTER_CYCLES - 1);

   // ************************************************************
   // crossings
   // ************************************************************
   logic                link_rstn;
   logic                cmd_tgl;
   logic                cmd_s;
   logic                scl_s;
   logic                sda_s;
   logic                done_tgl;
   logic                done_s;
   twowire_pkg::cmd_t   cmd;
   twowire_pkg::done_t  done_info;

   // release of link reset is retimed onto link_clk
   bit_sync #(.WIDTH(1)) u_link_rst
   (
      .clk  (link_clk),
      .rstn (presetn),
      .d    (1'b1),
      .q    (link_rstn)
   );

   bit_sync #(.WIDTH(3)) u_to_link
   (
      .clk  (link_clk),
      .rstn (link_rstn),
      .d    ({cmd_tgl, scl_i, sda_i}),
      .q    ({cmd_s, scl_s, sda_s})
   );

   bit_sync #(.WIDTH(1)) u_to_apb
   (
      .clk  (pclk),
      .rstn (presetn),
      .d    (done_tgl),
      .q    (done_s)
   );

   // ************************************************************
   // register front end (pclk)
   // ************************************************************
   logic                 flag, next_flag;
   logic                 ack_en, next_ack_en;
   logic                 start_req, next_start_req;
   logic                 stop_req, next_stop_req;
   logic                 wcol, next_wcol;
   logic                 enable, next_enable;
   logic                 irq_en, next_irq_en;
   logic [4:0]           code, next_code;
   logic [1:0]           presc, next_presc;
   logic [7:0]           shift, next_shift;
   logic                 pending, next_pending;
   logic                 done_prev, next_done_prev;
   logic                 next_cmd_tgl;
   twowire_pkg::cmd_t    next_cmd;
   logic [31:0]          next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;
   logic                 next_irq;
   logic                 setup, access, mapped;
   logic [7:0]           ctl_rd;

   always_comb
   begin
      setup  = psel && !penable;
      access = psel && penable && pready;
      mapped = (paddr == twowire_pkg::OFF_CONTROL) ||
               (paddr == twowire_pkg::OFF_STATUS)  ||
               (paddr == twowire_pkg::OFF_SHIFT);
      ctl_rd = {flag, ack_en, start_req, stop_req, wcol, enable, 1'b0,
                irq_en};

      next_flag      = flag;
      next_ack_en    = ack_en;
      next_start_req = start_req;
      next_stop_req  = stop_req;
      next_wcol      = wcol;
      next_enable    = enable;
      next_irq_en    = irq_en;
      next_code      = code;
      next_presc     = presc;
      next_shift     = shift;
      next_pending   = pending;
      next_done_prev = done_s;
      next_cmd_tgl   = cmd_tgl;
      next_cmd       = cmd;
      next_prdata    = prdata;
      next_pready    = setup;
      next_pslverr   = setup && !mapped;
      next_irq       = flag && irq_en && cpu_irq_enable;

      if (setup)
      begin
         unique case (paddr)
            twowire_pkg::OFF_CONTROL: next_prdata = {24'h0, ctl_rd};
            twowire_pkg::OFF_STATUS:  next_prdata =
               {24'h0, code, 1'b0, presc};
            twowire_pkg::OFF_SHIFT:   next_prdata = {24'h0, shift};
            default:                  next_prdata = 32'h0;
         endcase
      end

      // hardware event first; a same-cycle done write then neither clears the flag nor launches
      if (done_s != done_prev)
      begin
         next_pending = 1'b0;
         unique case (done_info.kind)
            twowire_pkg::EV_STOP:
               next_stop_req = 1'b0;
            twowire_pkg::EV_START:
            begin
               next_flag = 1'b1;
               next_code = twowire_pkg::CODE_START;
            end
            twowire_pkg::EV_ADDR:
            begin
               next_flag = 1'b1;
               next_code = done_info.nack ? twowire_pkg::CODE_ADDR_NACK
                                          : twowire_pkg::CODE_ADDR_ACK;
            end
            twowire_pkg::EV_DATA:
            begin
               next_flag = 1'b1;
               next_code = done_info.nack ? twowire_pkg::CODE_DATA_NACK
                                          : twowire_pkg::CODE_DATA_ACK;
            end
         endcase
      end

      if (access && pwrite)
      begin
         if (paddr == twowire_pkg::OFF_CONTROL)
         begin
            next_ack_en    = pwdata[twowire_pkg::CTL_ACK_EN];
            next_start_req = pwdata[twowire_pkg::CTL_START];
            next_stop_req  = pwdata[twowire_pkg::CTL_STOP];
            next_enable    = pwdata[twowire_pkg::CTL_ENABLE];
            next_irq_en    = pwdata[twowire_pkg::CTL_IRQ_EN];
            if (pwdata[twowire_pkg::CTL_DONE] && !next_flag)
            begin
               // writing one is a clear, never a set
            end
            if (pwdata[twowire_pkg::CTL_DONE] && flag &&
                (done_s == done_prev))
            begin
               next_flag = 1'b0;
            end
            // launch only when the done bit is written with enable and nothing runs
            if (pwdata[twowire_pkg::CTL_DONE] &&
                pwdata[twowire_pkg::CTL_ENABLE] && !pending &&
                (done_s == done_prev))
            begin
               next_pending = 1'b1;
               next_cmd_tgl = !cmd_tgl;
               next_cmd.data = shift;
               if (pwdata[twowire_pkg::CTL_START])
               begin
                  next_cmd.kind = twowire_pkg::OP_START;
               end
               else if (pwdata[twowire_pkg::CTL_STOP])
               begin
                  next_cmd.kind = twowire_pkg::OP_STOP;
               end
               else
               begin
                  next_cmd.kind = twowire_pkg::OP_BYTE;
               end
            end
         end
         else if (paddr == twowire_pkg::OFF_STATUS)
         begin
            next_presc = pwdata[twowire_pkg::ST_PRESC_W-1:0];
         end
         else if (paddr == twowire_pkg::OFF_SHIFT)
         begin
            // byte is frozen while the engine may be shifting it
            if (flag)
            begin
               next_shift = pwdata[7:0];
               next_wcol  = 1'b0;
            end
            else
            begin
               next_wcol  = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag      <= 1'b0;
         ack_en    <= 1'b0;
         start_req <= 1'b0;
         stop_req  <= 1'b0;
         wcol      <= 1'b0;
         enable    <= 1'b0;
         irq_en    <= 1'b0;
         code      <= twowire_pkg::CODE_IDLE;
         presc     <= '0;
         shift     <= twowire_pkg::SHIFT_RESET;
         pending   <= 1'b0;
         done_prev <= 1'b0;
         cmd_tgl   <= 1'b0;
         cmd       <= '0;
         prdata    <= 32'h0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         irq       <= 1'b0;
      end
      else
      begin
         flag      <= next_flag;
         ack_en    <= next_ack_en;
         start_req <= next_start_req;
         stop_req  <= next_stop_req;
         wcol      <= next_wcol;
         enable    <= next_enable;
         irq_en    <= next_irq_en;
         code      <= next_code;
         presc     <= next_presc;
         shift     <= next_shift;
         pending   <= next_pending;
         done_prev <= next_done_prev;
         cmd_tgl   <= next_cmd_tgl;
         cmd       <= next_cmd;
         prdata    <= next_prdata;
         pready    <= next_pready;
         pslverr   <= next_pslverr;
         irq       <= next_irq;
      end
   end

   // ************************************************************
   // bus engine (link_clk)
   // ************************************************************
   twowire_pkg::eng_state_t        st, next_st;
   logic [1:0]                     qtr, next_qtr;
   logic [twowire_pkg::CNT_W-1:0]  cnt, next_cnt;
   logic [2:0]                     bitn, next_bitn;
   logic [7:0]                     shreg, next_shreg;
   logic                           next_scl_oe, next_sda_oe;
   logic                           next_done_tgl;
   twowire_pkg::done_t             next_done_info;
   logic                           master, next_master;
   logic                           busy, next_busy;
   logic                           first, next_first;
   logic                           sda_prev, cmd_prev;
   logic                           step, stall;

   always_comb
   begin
      next_st        = st;
      next_qtr       = qtr;
      next_cnt       = cnt;
      next_bitn      = bitn;
      next_shreg     = shreg;
      next_scl_oe    = scl_oe;
      next_sda_oe    = sda_oe;
      next_done_tgl  = done_tgl;
      next_done_info = done_info;
      next_master    = master;
      next_busy      = busy;
      next_first     = first;
      step           = 1'b0;

      // other masters' START and STOP mark the bus busy or free
      if (scl_s && sda_prev && !sda_s)
      begin
         next_busy = 1'b1;
      end
      else if (scl_s && !sda_prev && sda_s)
      begin
         next_busy = 1'b0;
      end

      // a slave holding SCL low freezes the bit timing
      stall = !scl_oe && !scl_s;
      if (!stall)
      begin
         if (cnt == CNT_LAST)
         begin
            next_cnt = '0;
            step     = 1'b1;
         end
         else
         begin
            next_cnt = cnt + 1'b1;
         end
      end

      unique case (st)
         twowire_pkg::S_IDLE,
         twowire_pkg::S_HOLD:
         begin
            next_cnt = '0;
            next_qtr = '0;
            if (cmd_s != cmd_prev)
            begin
               unique case (cmd.kind)
                  twowire_pkg::OP_START:
                     next_st = (busy && !master) ?
                               twowire_pkg::S_WAIT_FREE :
                               twowire_pkg::S_START;
                  twowire_pkg::OP_STOP:
                     next_st = twowire_pkg::S_STOP;
                  default:
                  begin
                     next_shreg = cmd.data;
                     next_bitn  = 3'(twowire_pkg::BITS_LAST);
                     next_st    = twowire_pkg::S_BIT;
                  end
               endcase
            end
         end
         twowire_pkg::S_WAIT_FREE:
         begin
            next_cnt = '0;
            if (!busy)
            begin
               next_st = twowire_pkg::S_START;
            end
         end
         twowire_pkg::S_START:
         begin
            if (step)
            begin
               next_qtr = qtr + 1'b1;
               unique case (qtr)
                  2'h0: next_sda_oe = 1'b0;
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_sda_oe = 1'b1;
                  default:
                  begin
                     next_scl_oe         = 1'b1;
                     next_master         = 1'b1;
                     next_first          = 1'b1;
                     next_done_info.kind = twowire_pkg::EV_START;
                     next_done_tgl       = !done_tgl;
                     next_st             = twowire_pkg::S_HOLD;
                  end
               endcase
            end
         end
         twowire_pkg::S_BIT:
         begin
            if (step)
            begin
               next_qtr = qtr + 1'b1;
               unique case (qtr)
                  2'h0: next_sda_oe = !shreg[7];
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_scl_oe = 1'b0;
                  default:
                  begin
                     next_scl_oe = 1'b1;
                     next_shreg  = {shreg[6:0], 1'b0};
                     next_bitn   = bitn - 1'b1;
                     if (bitn == 3'h0)
                     begin
                        next_st = twowire_pkg::S_ACK;
                     end
                  end
               endcase
            end
         end
         twowire_pkg::S_ACK:
         begin
            if (step)
            begin
               next_qtr = qtr + 1'b1;
               unique case (qtr)
                  2'h0: next_sda_oe = 1'b0;
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_done_info.nack = sda_s;
                  default:
                  begin
                     next_scl_oe         = 1'b1;
                     next_done_info.kind = first ? twowire_pkg::EV_ADDR
                                                 : twowire_pkg::EV_DATA;
                     next_first          = 1'b0;
                     next_done_tgl       = !done_tgl;
                     next_st             = twowire_pkg::S_HOLD;
                  end
               endcase
            end
         end
         twowire_pkg::S_STOP:
         begin
            if (step)
            begin
               next_qtr = qtr + 1'b1;
               unique case (qtr)
                  2'h0: next_sda_oe = 1'b1;
                  2'h1: next_scl_oe = 1'b0;
                  2'h2: next_sda_oe = 1'b0;
                  default:
                  begin
                     next_master         = 1'b0;
                     next_done_info.kind = twowire_pkg::EV_STOP;
                     next_done_tgl       = !done_tgl;
                     next_st             = twowire_pkg::S_IDLE;
                  end
               endcase
            end
         end
         default:
         begin
            next_scl_oe = 1'b0;
            next_sda_oe = 1'b0;
            next_st     = twowire_pkg::S_IDLE;
         end
      endcase

      // hold keeps SCL pulled low until software answers
      if (next_st == twowire_pkg::S_HOLD)
      begin
         next_scl_oe = 1'b1;
      end
   end

   always_ff @(posedge link_clk or negedge link_rstn)
   begin
      if (!link_rstn)
      begin
         st        <= twowire_pkg::S_IDLE;
         qtr       <= '0;
         cnt       <= '0;
         bitn      <= '0;
         shreg     <= '0;
         scl_oe    <= 1'b0;
         sda_oe    <= 1'b0;
         scl_o     <= 1'b0;
         sda_o     <= 1'b0;
         done_tgl  <= 1'b0;
         done_info <= '0;
         master    <= 1'b0;
         busy      <= 1'b0;
         first     <= 1'b0;
         sda_prev  <= 1'b1;
         cmd_prev  <= 1'b0;
      end
      else
      begin
         st        <= next_st;
         qtr       <= next_qtr;
         cnt       <= next_cnt;
         bitn      <= next_bitn;
         shreg     <= next_shreg;
         scl_oe    <= next_scl_oe;
         sda_oe    <= next_sda_oe;
         scl_o     <= 1'b0;
         sda_o     <= 1'b0;
         done_tgl  <= next_done_tgl;
         done_info <= next_done_info;
         master    <= next_master;
         busy      <= next_busy;
         first     <= next_first;
         sda_prev  <= sda_s;
         cmd_prev  <= cmd_s;
      end
   end

endmodule : twowire_sw_handshake_master_tx

`default_nettype wire

//--- twowire_props.sv
// twowire_props: port checks of the two-wire master.
// assumes: bound onto the block, pclk domain only.
`default_nettype none
module twowire_props
(
   // apb, irq, clock pin
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cpu_irq_enable,
   input wire logic        irq,
   input wire logic        scl_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
   chk_setup_ready: assert property (psel && !penable |=> pready)
      else $error("late answer");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready too long");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("stray error");
   chk_irq_gate: assert property (irq |-> $past(cpu_irq_enable))
      else $error("irq ungated");
   chk_irq_drop: assert property (!cpu_irq_enable |=> !irq)
      else $error("irq kept");
   chk_scl_hold: assert property ($rose(irq) |-> scl_oe)
      else $error("scl free");
   chk_flag_clear: assert property (wr0 && pwdata[7] && irq
      |-> ##[1:2] !irq) else $error("flag kept");
   chk_flag_keep: assert property (wr0 && pwdata[7:0] == 8'h05 && irq
      |-> ##2 irq) else $error("flag lost");
   cover property (wr0 && pwdata[7]);
   cover property ($rose(irq));
   cover property (pslverr);
endmodule : twowire_props
bind twowire_sw_handshake_master_tx twowire_props twowire_props_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .cpu_irq_enable, .irq, .scl_oe);
`default_nettype wire

//--- twowire_slave_model.sv
// twowire_slave_model: receiving target on the two-wire bus.
// assumes: scl and sda are resolved levels with pull-ups.
`default_nettype none
module twowire_slave_model
(
   // bus levels, refusal, ack drive
   input wire logic   scl,
   input wire logic   sda,
   input wire logic   nack,
   output logic       ack_oe = 1'b0,
   output logic [7:0] got
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   always @(negedge sda) if (scl) n <= 0;
   always @(posedge scl) n <= (n == 9) ? 1 : n + 1;
   always @(posedge scl) got <= (n != 8) ? {got[6:0], sda} : got;
   // refusal leaves the ninth bit to the pull-up
   always @(negedge scl) ack_oe <= n == 8 && !nack;
endmodule : twowire_slave_model
`default_nettype wire

//--- twowire_sw_handshake_master_tx_tb_top.sv
// tb top: apb software side, a target model on the wire.
// assumes: quarter of 4 link clocks; run takes about 6 us.
`default_nettype none
module twowire_sw_handshake_master_tx_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic cpu_irq_enable = 1, link_clk = 0, nack = 0, pready, pslverr, irq;
   logic scl_o, scl_oe, sda_o, sda_oe, ack_oe;
   logic [7:0] paddr = 8'h00, got;
   logic [31:0] pwdata = 32'h0, prdata, r;
   int err_total = 0, n_checks = 0;
   wire scl = scl_oe ? scl_o : 1'b1;
   wire sda = ack_oe ? 1'b0 : sda_oe ? sda_o : 1'b1;
   always #12.5 pclk = ~pclk;
   always #6 link_clk = ~link_clk;
   twowire_sw_handshake_master_tx #(.QUARTER_CYCLES(4))
      twowire_sw_handshake_master_tx_inst (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_irq_enable,
      .irq, .link_clk, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
      .sda_oe);
   twowire_slave_model twowire_slave_model_inst (.scl, .sda, .nack, .ack_oe,
      .got);
   task automatic chk(input logic [31:0] s, x);
      n_checks++;
      err_total += int'(s !== x);
      if (s !== x)
         $display("MISMATCH %0t %h not %h", $time, s, x);
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic step(logic [7:0] c, logic [4:0] code);
      apb(1'b1, 8'h00, {24'h0, c});
      do apb(1'b0, 8'h00, 32'h0); while (r[7] !== 1'b1);
      apb(1'b0, 8'h04, 32'h0);
      chk(r, {24'h0, code, 3'h0});
   endtask : step
   task automatic t_regs;
      apb(1'b0, 8'h0C, 32'h0);
      chk({r[30:0], e}, 32'h1);
      apb(1'b1, 8'h04, 32'h3);
      apb(1'b0, 8'h04, 32'h0);
      chk(r, {24'h0, twowire_pkg::CODE_IDLE, 3'h3});
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h08, 32'h11);
      apb(1'b0, 8'h00, 32'h0);
      chk(r, 32'h08);
      $display("register test done");
   endtask : t_regs
   task automatic t_tx;
      step(8'hA5, twowire_pkg::CODE_START);
      apb(1'b1, 8'h08, 32'hA0);
      apb(1'b1, 8'h00, 32'h05);
      apb(1'b0, 8'h00, 32'h0);
      chk(r, 32'h85);
      step(8'h85, twowire_pkg::CODE_ADDR_ACK);
      chk(got, 8'hA0);
      nack <= 1'b1;
      apb(1'b1, 8'h08, 32'h3C);
      step(8'h85, twowire_pkg::CODE_DATA_NACK);
      chk(got, 8'h3C);
      chk(scl, 1'b0);
      chk(irq, 1'b1);
      cpu_irq_enable <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, 8'h00, 32'h95);
      do apb(1'b0, 8'h00, 32'h0); while (r[4] !== 1'b0);
      chk(r[7], 1'b0);
      chk(sda, 1'b1);
      $display("transmit test done");
   endtask : t_tx
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_tx;
      tally_and_finish;
   end
   initial
   begin
      #200us;
      err_total++;
      tally_and_finish;
   end
endmodule : twowire_sw_handshake_master_tx_tb_top
`default_nettype wire
